// File: rtl/scsl_pkg.sv
// Constants, types and register map of the axis speed change and stroke check block
package scsl_pkg;

  // Clock and timing
  localparam int CLK_NS    = 8;
  localparam int TICK_US   = 1000;
  localparam int TICK_CYC  = TICK_US * 1000 / CLK_NS;
  localparam int CALC_NS   = 80;
  localparam int CALC_CYC  = (CALC_NS + CLK_NS - 1) / CLK_NS;

  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_NEWSPD = 8'h04;
  localparam logic [7:0] A_CMDSPD = 8'h08;
  localparam logic [7:0] A_SPDLIM = 8'h0c;
  localparam logic [7:0] A_BIAS   = 8'h10;
  localparam logic [7:0] A_ACCT   = 8'h14;
  localparam logic [7:0] A_DECT   = 8'h18;
  localparam logic [7:0] A_TARGET = 8'h1c;
  localparam logic [7:0] A_STRUP  = 8'h20;
  localparam logic [7:0] A_STRLO  = 8'h24;
  localparam logic [7:0] A_ORG    = 8'h28;
  localparam logic [7:0] A_STBY   = 8'h2c;
  localparam logic [7:0] A_NEWVAL = 8'h30;
  localparam logic [7:0] A_FEEDLO = 8'h34;
  localparam logic [7:0] A_FEEDHI = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h3c;
  localparam logic [7:0] A_CODES  = 8'h40;

  // Control word fields
  localparam int CTL_START = 0;
  localparam int CTL_SPCHG = 1;
  localparam int CTL_TPCHG = 2;
  localparam int CTL_STOP  = 3;
  localparam int CTL_MODE  = 4;
  localparam int CTL_REV   = 8;
  localparam int CTL_STBY  = 9;

  // Warning and error codes (1020, 1022, 1103, 1104, 1502, 1503)
  localparam logic [15:0] W_RANGE = 16'h03fc;
  localparam logic [15:0] W_NOCHG = 16'h03fe;
  localparam logic [15:0] E_UP    = 16'h044f;
  localparam logic [15:0] E_LO    = 16'h0450;
  localparam logic [15:0] E_ACC   = 16'h05de;
  localparam logic [15:0] E_DEC   = 16'h05df;

  // Operation status values
  localparam logic [15:0] OST_STANDBY = 16'h0000;
  localparam logic [15:0] OST_RUN     = 16'h0001;
  localparam logic [15:0] OST_ERR     = 16'hffff;

  // Reset values and limits
  localparam logic [31:0] RST_SPDLIM = 32'h00010000;
  localparam logic [31:0] RST_BIAS   = 32'h00000000;
  localparam logic [31:0] RST_STRUP  = 32'h7fffffff;
  localparam logic [31:0] RST_STRLO  = 32'h80000000;
  localparam logic [31:0] TIME_MAX   = 32'h0000ffff;

  typedef enum logic [2:0] {
    MD_MACH_ORG, MD_FAST_ORG, MD_POS, MD_SPEED,
    MD_SPDPOS, MD_CURCHG, MD_JOG, MD_ABSRST
  } scsl_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_CONST, ST_DEC} scsl_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scsl_bus_t;

endpackage : scsl_pkg

// File: rtl/scsl_axis.sv
// Single pulse axis: speed change handling and software stroke checks at start
// Contract
// - New speed above limit runs at limit, warning 1020.
// - New speed below bias runs at bias, warning 1020.
// - Speed change ignored while previous change still calculating.
// - New speed applied only after current pulse completes.
// - Target reached during speed change processing gives 1022, speed unchanged.
// - Target change with simultaneous speed change cancels speed change, 1022.
// - Target change during acceleration switches to constant speed.
// - Position completes at target even before speed falls to bias.
// - Bias 0 and new speed 0 stops axis, busy and status kept.
// - Nonzero bias with new speed 0 gives 1020, runs at bias.
// - Time error while at speed 0 stops axis, status -1.
// - Time error sets status error; position finishes, speed decelerates on old time.
// - Jog time error decelerates on prior stop time.
// - Stop time is referenced to the new speed value.
// - Stroke check at start, addresses relative to established origin.
// - No start check for origin return, speed, speed phase, restore.
// - Fast origin return out of range gives 1103/1104, no start.
// - Position control out of range feed or target blocks start.
// - Out of range current value change rejected, value kept.
// - Jog outward from outside range refused, inward allowed.
// - Switching control started with switch on begins in position phase.
`timescale 1ns/1ns
`default_nettype none
module scsl_axis
  import scsl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset_n,
  // Register port
  input  wire scsl_bus_t bus,
  output logic [31:0]    rd_data,
  // External switch command
  input  wire logic      ext_switch,
  // Motor drive
  output logic           pulse_out,
  output logic           dir_out,
  output logic           axis_busy_flag
);

  ////////////////////////////////////////////////////////////////////
  logic        [31:0] spd_lim_q, bias_q, cmd_spd_q, new_spd_q;
  logic        [31:0] acc_t_q, dec_t_q;
  logic signed [31:0] target_q, st_up_q, st_lo_q, org_q, stby_q;
  logic signed [31:0] newval_q, feed_q, run_tgt_q;
  logic        [31:0] speed_q, tgt_q, acc_q, dec_q, pend_spd_q;
  logic        [31:0] phase_q, tick_cnt_q;
  logic        [15:0] ost_q, warn_q, err_q;
  logic        [7:0]  calc_q;
  scsl_state_t        st_q;
  scsl_mode_t         mode_q;
  logic               pend_q, errf_q, spos_q, dir_q, ext_q;

  // Speed clamped to limit and bias, flag when clamped
  function automatic logic [32:0] clamp(input logic [31:0] v);
    if (v > spd_lim_q) begin
      clamp = {1'b1, spd_lim_q};
    end else if (v < bias_q) begin
      clamp = {1'b1, bias_q};
    end else begin
      clamp = {1'b0, v};
    end
  endfunction : clamp

  // Ramp step per tick; a zero time means a one tick ramp
  function automatic logic [31:0] step(input logic [31:0] spd,
                                       input logic [31:0] t);
    logic [31:0] s;
    s = (t == 32'h0) ? spd : spd / t;
    step = (s == 32'h0) ? 32'h1 : s;
  endfunction : step

  // Stroke limit code for an address, zero when inside
  function automatic logic [15:0] chk(input logic signed [31:0] x);
    if (x > st_up_q) begin
      chk = E_UP;
    end else if (x < st_lo_q) begin
      chk = E_LO;
    end else begin
      chk = 16'h0000;
    end
  endfunction : chk

  ////////////////////////////////////////////////////////////////////
  // Command decode
  logic        wr_ctl, cmd_start, cmd_spchg, cmd_tpchg, cmd_stop;
  logic        tick, carry, pos_ctl, bad_acc, bad_dec;
  logic [32:0] phase_sum, new_cl, cmd_cl;
  logic signed [31:0] feed_nxt;
  scsl_mode_t  new_mode;

  always_comb begin
    wr_ctl    = bus.wr && (bus.addr == A_CTRL);
    cmd_start = wr_ctl && bus.wdata[CTL_START];
    cmd_spchg = wr_ctl && bus.wdata[CTL_SPCHG];
    cmd_tpchg = wr_ctl && bus.wdata[CTL_TPCHG];
    cmd_stop  = wr_ctl && bus.wdata[CTL_STOP];
    new_mode  = scsl_mode_t'(bus.wdata[CTL_MODE +: 3]);
    tick      = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    phase_sum = {1'b0, phase_q} + {1'b0, speed_q};
    carry     = phase_sum[32] && (st_q != ST_IDLE);
    feed_nxt  = dir_q ? feed_q + 32'sh1 : feed_q - 32'sh1;
    pos_ctl   = (mode_q == MD_POS) || (mode_q == MD_FAST_ORG) ||
                ((mode_q == MD_SPDPOS) && spos_q);
    bad_acc   = (acc_t_q == 32'h0) || (acc_t_q > TIME_MAX);
    bad_dec   = (dec_t_q == 32'h0) || (dec_t_q > TIME_MAX);
    new_cl    = clamp(new_spd_q);
    cmd_cl    = clamp(cmd_spd_q);
  end

  // Start checks per control type
  logic [15:0]        s_err;
  logic signed [31:0] s_tgt;
  logic               s_run, s_spos, s_dir;

  always_comb begin
    s_err  = 16'h0000;
    s_tgt  = target_q;
    s_run  = 1'b1;
    s_spos = 1'b0;
    s_dir  = !bus.wdata[CTL_REV];
    case (new_mode)
      MD_FAST_ORG: begin
        s_tgt = bus.wdata[CTL_STBY] ? stby_q : org_q;
        s_err = (chk(feed_q) != 16'h0) ? chk(feed_q) : chk(s_tgt);
      end
      MD_POS: begin
        s_err = (chk(feed_q) != 16'h0) ? chk(feed_q) : chk(s_tgt);
      end
      MD_SPDPOS: begin
        if (ext_switch) begin
          s_spos = 1'b1;
          s_tgt  = feed_q + target_q;
          s_err  = (chk(feed_q) != 16'h0) ? chk(feed_q) : chk(s_tgt);
        end
      end
      MD_JOG: begin
        if ((feed_q > st_up_q && s_dir) || (feed_q < st_lo_q && !s_dir)) begin
          s_err = chk(feed_q);
        end
      end
      MD_CURCHG: begin
        s_run = 1'b0;
        s_err = chk(newval_q);
      end
      // Origin return, speed control and restore start unchecked
      default: s_run = (new_mode == MD_SPEED);
    endcase
    if (s_spos || new_mode == MD_POS || new_mode == MD_FAST_ORG) begin
      s_dir = (s_tgt > feed_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spd_lim_q <= RST_SPDLIM;
      bias_q    <= RST_BIAS;
      cmd_spd_q <= 32'h0;
      new_spd_q <= 32'h0;
      acc_t_q   <= 32'h0;
      dec_t_q   <= 32'h0;
      target_q  <= 32'sh0;
      st_up_q   <= RST_STRUP;
      st_lo_q   <= RST_STRLO;
      org_q     <= 32'sh0;
      stby_q    <= 32'sh0;
      newval_q  <= 32'sh0;
    end else if (bus.wr) begin
      case (bus.addr)
        A_SPDLIM: spd_lim_q <= bus.wdata;
        A_BIAS:   bias_q    <= bus.wdata;
        A_CMDSPD: cmd_spd_q <= bus.wdata;
        A_NEWSPD: new_spd_q <= bus.wdata;
        A_ACCT:   acc_t_q   <= bus.wdata;
        A_DECT:   dec_t_q   <= bus.wdata;
        A_TARGET: target_q  <= bus.wdata;
        A_STRUP:  st_up_q   <= bus.wdata;
        A_STRLO:  st_lo_q   <= bus.wdata;
        A_ORG:    org_q     <= bus.wdata;
        A_STBY:   stby_q    <= bus.wdata;
        A_NEWVAL: newval_q  <= bus.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pulse train and ramp tick
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_q    <= 32'h0;
      tick_cnt_q <= 32'h0;
      pulse_out  <= 1'b0;
      dir_out    <= 1'b0;
      ext_q      <= 1'b0;
    end else begin
      phase_q    <= (st_q == ST_IDLE) ? 32'h0 : phase_sum[31:0];
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      pulse_out  <= carry;
      dir_out    <= dir_q;
      ext_q      <= ext_switch;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Motion, speed change and status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q           <= ST_IDLE;
      mode_q         <= MD_MACH_ORG;
      speed_q        <= 32'h0;
      tgt_q          <= 32'h0;
      acc_q          <= 32'h1;
      dec_q          <= 32'h1;
      pend_spd_q     <= 32'h0;
      pend_q         <= 1'b0;
      calc_q         <= 8'h00;
      errf_q         <= 1'b0;
      spos_q         <= 1'b0;
      dir_q          <= 1'b0;
      feed_q         <= 32'sh0;
      run_tgt_q      <= 32'sh0;
      ost_q          <= OST_STANDBY;
      warn_q         <= 16'h0000;
      err_q          <= 16'h0000;
      axis_busy_flag <= 1'b0;
    end else begin
      // Clear first so a code raised this cycle survives
      if (bus.wr && bus.addr == A_CODES) begin
        warn_q <= 16'h0000;
        err_q  <= 16'h0000;
      end
      // Ramp once per tick
      if (tick) begin
        case (st_q)
          ST_ACC: begin
            if (speed_q < tgt_q) begin
              speed_q <= (tgt_q - speed_q > acc_q) ? speed_q + acc_q : tgt_q;
            end else if (speed_q > tgt_q) begin
              speed_q <= (speed_q - tgt_q > acc_q) ? speed_q - acc_q : tgt_q;
            end else begin
              st_q <= ST_CONST;
            end
          end
          ST_DEC: begin
            if ({1'b0, speed_q} <= {1'b0, bias_q} + {1'b0, dec_q}) begin
              st_q           <= ST_IDLE;
              speed_q        <= 32'h0;
              axis_busy_flag <= 1'b0;
              if (!errf_q) ost_q <= OST_STANDBY;
            end else begin
              speed_q <= speed_q - dec_q;
            end
          end
          default: ;
        endcase
      end
      // Speed change calculation delay
      if (calc_q != 8'h00) begin
        calc_q <= calc_q - 8'h01;
        if (calc_q == 8'h01) pend_q <= 1'b1;
      end
      // Apply only at a pulse boundary, or at once when no pulse runs
      if (pend_q && (carry || speed_q == 32'h0)) begin
        pend_q <= 1'b0;
        tgt_q  <= pend_spd_q;
        st_q   <= ST_ACC;
        // Ramp by the size of the change, so a change to zero really ends
        acc_q  <= step((pend_spd_q > speed_q) ? pend_spd_q - speed_q
                                              : speed_q - pend_spd_q, acc_t_q);
        dec_q  <= step(pend_spd_q, dec_t_q);
      end
      // Switch to position phase on switch edge
      if (axis_busy_flag && mode_q == MD_SPDPOS && !spos_q && ext_switch && !ext_q) begin
        spos_q    <= 1'b1;
        run_tgt_q <= feed_q + target_q;
        dir_q     <= target_q > 32'sh0;
      end
      // Speed change request; busy calculation or deceleration ignores it
      if (cmd_spchg && axis_busy_flag && calc_q == 8'h00 && !pend_q && st_q != ST_DEC) begin
        if (cmd_tpchg) begin
          warn_q <= W_NOCHG;
        end else if (pos_ctl && st_q != ST_CONST) begin
          warn_q <= W_NOCHG;
        end else if (bad_acc || bad_dec) begin
          err_q  <= bad_acc ? E_ACC : E_DEC;
          ost_q  <= OST_ERR;
          errf_q <= 1'b1;
          if (speed_q == 32'h0) begin
            st_q           <= ST_IDLE;
            axis_busy_flag <= 1'b0;
          end else if (!pos_ctl) begin
            st_q <= ST_DEC;
          end
        end else begin
          calc_q     <= 8'(CALC_CYC);
          pend_spd_q <= new_cl[31:0];
          if (new_cl[32]) warn_q <= W_RANGE;
        end
      end
      // Target change; out of range targets are not taken
      if (cmd_tpchg && axis_busy_flag && pos_ctl && chk(target_q) == 16'h0000) begin
        run_tgt_q <= target_q;
        dir_q     <= target_q > feed_q;
        if (st_q == ST_ACC) begin
          st_q  <= ST_CONST;
          tgt_q <= speed_q;
        end
      end
      if (cmd_stop && axis_busy_flag) st_q <= ST_DEC;
      // Feed count and completion at target
      if (carry) begin
        feed_q <= feed_nxt;
        if (pos_ctl && feed_nxt == run_tgt_q) begin
          st_q           <= ST_IDLE;
          speed_q        <= 32'h0;
          axis_busy_flag <= 1'b0;
          calc_q         <= 8'h00;
          pend_q         <= 1'b0;
          if (!errf_q) ost_q <= OST_STANDBY;
          if (calc_q != 8'h00 || pend_q) warn_q <= W_NOCHG;
        end
      end
      // Start of an operation with stroke check
      if (cmd_start && !axis_busy_flag) begin
        mode_q <= new_mode;
        spos_q <= s_spos;
        errf_q <= 1'b0;
        ost_q  <= OST_STANDBY;
        if (s_err != 16'h0000) begin
          err_q  <= s_err;
          ost_q  <= OST_ERR;
          errf_q <= 1'b1;
        end else if (new_mode == MD_CURCHG) begin
          feed_q <= newval_q;
        end else if (new_mode == MD_MACH_ORG) begin
          feed_q <= org_q;
        end else if (s_run) begin
          axis_busy_flag <= 1'b1;
          ost_q          <= OST_RUN;
          st_q           <= ST_ACC;
          run_tgt_q      <= s_tgt;
          dir_q          <= s_dir;
          speed_q        <= bias_q;
          tgt_q          <= cmd_cl[31:0];
          acc_q          <= step(cmd_cl[31:0], acc_t_q);
          dec_q          <= step(cmd_cl[31:0], dec_t_q);
          if (cmd_cl[32]) warn_q <= W_RANGE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data <= 32'h0;
    end else if (bus.rd) begin
      case (bus.addr)
        A_NEWSPD: rd_data <= new_spd_q;
        A_CMDSPD: rd_data <= cmd_spd_q;
        A_SPDLIM: rd_data <= spd_lim_q;
        A_BIAS:   rd_data <= bias_q;
        A_ACCT:   rd_data <= acc_t_q;
        A_DECT:   rd_data <= dec_t_q;
        A_TARGET: rd_data <= target_q;
        A_STRUP:  rd_data <= st_up_q;
        A_STRLO:  rd_data <= st_lo_q;
        A_ORG:    rd_data <= org_q;
        A_STBY:   rd_data <= stby_q;
        A_NEWVAL: rd_data <= newval_q;
        A_FEEDLO: rd_data <= {16'h0000, feed_q[15:0]};
        A_FEEDHI: rd_data <= {16'h0000, feed_q[31:16]};
        A_STATUS: rd_data <= {ost_q, 11'h000, spos_q, pend_q,
                              (calc_q != 8'h00), dir_q, axis_busy_flag};
        A_CODES:  rd_data <= {err_q, warn_q};
        default:  rd_data <= 32'h0;
      endcase
    end else begin
      rd_data <= 32'h0;
    end
  end

endmodule : scsl_axis
`default_nettype wire

// File: verification/scsl_axis_chk.sv
// Port assertions for the speed change and stroke check axis
`timescale 1ns/1ns
`default_nettype none
module scsl_axis_chk
  import scsl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Register port
  input wire scsl_bus_t   bus,
  input wire logic [31:0] rd_data,
  // Switch and drive side
  input wire logic        ext_switch,
  input wire logic        pulse_out,
  input wire logic        dir_out,
  input wire logic        axis_busy_flag
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  logic [31:0] lim_q, up_q, lo_q, tgt_q, home_q, stby_q, gap_q;
  logic        run_q;
  logic        start_w;
  logic [2:0]  mode_w;
  logic [31:0] dest_w;
  assign start_w = bus.wr && bus.addr == A_CTRL && bus.wdata[CTL_START] && !axis_busy_flag;
  assign mode_w  = bus.wdata[CTL_MODE+:3];
  assign dest_w  = bus.wdata[CTL_STBY] ? stby_q : home_q;
  function automatic logic outside(input logic [31:0] a);
    return $signed(a) > $signed(up_q) || $signed(a) < $signed(lo_q);
  endfunction : outside
  // Shadow of what software wrote, so limits need no peek inside
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lim_q <= RST_SPDLIM;
      up_q  <= RST_STRUP;
      lo_q  <= RST_STRLO;
    end else if (bus.wr && bus.addr == A_SPDLIM) lim_q <= bus.wdata;
    else if (bus.wr && bus.addr == A_STRUP) up_q <= bus.wdata;
    else if (bus.wr && bus.addr == A_STRLO) lo_q <= bus.wdata;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tgt_q  <= 32'h0;
      home_q <= 32'h0;
      stby_q <= 32'h0;
    end else if (bus.wr && bus.addr == A_TARGET) tgt_q <= bus.wdata;
    else if (bus.wr && bus.addr == A_ORG) home_q <= bus.wdata;
    else if (bus.wr && bus.addr == A_STBY) stby_q <= bus.wdata;
  end
  // Cycles since last pulse; first gap of a run is skipped, phase is unknown
  always_ff @(posedge clk) begin
    if (!reset_n || !axis_busy_flag) begin
      gap_q <= 32'h0;
      run_q <= 1'b0;
    end else if (pulse_out) begin
      gap_q <= 32'h1;
      run_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  chk_read_zero_idle: assert property (!$past(bus.rd) |-> rd_data == 32'h0)
    else $error("read data not zero outside the answer cycle");
  chk_reset_outs_low: assert property ($past(!reset_n) |-> !pulse_out && !axis_busy_flag)
    else $error("outputs not low after reset");
  chk_idle_no_pulse: assert property (!axis_busy_flag && !$past(axis_busy_flag) |-> !pulse_out)
    else $error("pulse issued while axis idle");
  chk_speed_no_check: assert property (start_w && mode_w == MD_SPEED |=> axis_busy_flag)
    else $error("speed control start refused");
  chk_pos_out_range: assert property (start_w && mode_w == MD_POS && outside(tgt_q) |=>
    (!axis_busy_flag) [*4])
    else $error("position start beyond stroke limits");
  chk_home_out_range: assert property (start_w && mode_w == MD_FAST_ORG && outside(dest_w)
    |-> ##1 !axis_busy_flag ##1 !axis_busy_flag && !pulse_out)
    else $error("fast return start beyond stroke limits");
  chk_limit_gap: assert property (pulse_out && run_q |->
    {32'h0, gap_q} * {32'h0, lim_q} + {32'h0, lim_q} >= 64'h100000000)
    else $error("pulse rate above speed limit");
  chk_dir_steady: assert property (axis_busy_flag && $past(axis_busy_flag) &&
    $past(axis_busy_flag, 2) |-> $stable(dir_out))
    else $error("direction changed during a run");
  cov_start: cover property (start_w);
  cov_pulse_gap: cover property (pulse_out && run_q);
  cov_finish: cover property ($fell(axis_busy_flag));
endmodule : scsl_axis_chk

bind scsl_axis scsl_axis_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk(clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data), .ext_switch(ext_switch),
  .pulse_out(pulse_out), .dir_out(dir_out), .axis_busy_flag(axis_busy_flag));
`default_nettype wire

// File: verification/scsl_drive.sv
// Motor drive model: counts step pulses into a signed position
`timescale 1ns/1ns
`default_nettype none
module scsl_drive (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  reset_n,
  // Pulse train
  input  wire logic  pulse_out,
  input  wire logic  dir_out,
  // Position reached
  output logic [31:0] pos_q
);
  always_ff @(posedge clk) begin
    if (!reset_n) pos_q <= 32'h0;
    else if (pulse_out) pos_q <= dir_out ? pos_q + 32'h1 : pos_q - 32'h1;
  end
endmodule : scsl_drive
`default_nettype wire

// File: verification/scsl_axis_bench.sv
// Testbench: register scenarios for the speed change and stroke check axis
`timescale 1ns/1ns
`default_nettype none
module scsl_axis_bench;
  import scsl_pkg::*;
  localparam logic [7:0]  RA [6] = '{A_SPDLIM, A_BIAS, A_STRUP, A_STRLO, A_STATUS, 8'h44};
  localparam logic [31:0] RV [6] = '{RST_SPDLIM, RST_BIAS, RST_STRUP, RST_STRLO, 32'h0, 32'h0};
  logic        clk;
  logic        reset_n;
  scsl_bus_t   bus_s;
  logic [31:0] rd_data;
  logic        ext_switch;
  logic        pulse_out;
  logic        dir_out;
  logic        axis_busy_flag;
  logic [31:0] pos;
  logic [31:0] d;
  logic [31:0] p0;
  int          err_total;
  int          comparisons;
  // Short tick keeps ramps to a few cycles
  scsl_axis #(.TICK_CYCLES(4)) uut (.clk(clk), .reset_n(reset_n), .bus(bus_s),
    .rd_data(rd_data), .ext_switch(ext_switch), .pulse_out(pulse_out), .dir_out(dir_out),
    .axis_busy_flag(axis_busy_flag));
  scsl_drive drive (.clk(clk), .reset_n(reset_n), .pulse_out(pulse_out), .dir_out(dir_out),
    .pos_q(pos));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus_s <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_s <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus_s <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_s <= '0;
    #1 d = rd_data;
    check(name, d, exp);
    @(posedge clk);
  endtask : rchk
  task automatic bchk(input logic b);
    #1 check("busy", {31'h0, axis_busy_flag}, {31'h0, b});
    @(posedge clk);
  endtask : bchk
  task automatic go(input logic [31:0] c, input logic b);
    wr(A_CTRL, c);
    bchk(b);
  endtask : go
  // Reads the codes, then clears them for the next case
  task automatic codes(input logic [31:0] exp);
    rchk("codes", A_CODES, exp);
    wr(A_CODES, 32'h0);
  endtask : codes
  task automatic stchk(input logic [31:0] st);
    rchk("status", A_STATUS, st);
  endtask : stchk
  task automatic spchg(input logic [31:0] v);
    wr(A_NEWSPD, v);
    wr(A_CTRL, 32'h2);
    repeat (20) @(posedge clk);
  endtask : spchg
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    #1;
    while (axis_busy_flag !== 1'b0 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    check("idle", {31'h0, axis_busy_flag}, 32'h0);
    @(posedge clk);
  endtask : wait_idle
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    err_total = 0;
    comparisons = 0;
    bus_s = '0;
    ext_switch = 1'b0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rchk("reset value", RA[i], RV[i]);
    wr(A_SPDLIM, 32'h10000000);
    wr(A_CMDSPD, 32'h08000000);
    wr(A_ACCT, 32'h2);
    wr(A_DECT, 32'h2);
    wr(A_STRUP, 32'd1000);
    wr(A_STRLO, 32'h0);
    wr(A_TARGET, 32'd2000);
    go(32'h21, 1'b0);
    codes({E_UP, 16'h0});
    wr(A_TARGET, 32'hfffffffb);
    go(32'h21, 1'b0);
    codes({E_LO, 16'h0});
    wr(A_NEWVAL, 32'd1500);
    wr(A_CTRL, 32'h51);
    codes({E_UP, 16'h0});
    rchk("feed", A_FEEDLO, 32'h0);
    wr(A_NEWVAL, 32'd100);
    wr(A_CTRL, 32'h51);
    rchk("feed", A_FEEDLO, 32'd100);
    wr(A_ORG, 32'd2000);
    go(32'h11, 1'b0);
    codes({E_UP, 16'h0});
    wr(A_STBY, 32'hffffffff);
    go(32'h211, 1'b0);
    codes({E_LO, 16'h0});
    $display("test start checks done");
    go(32'h31, 1'b1);
    repeat (40) @(posedge clk);
    spchg(32'h20000000);
    codes({16'h0, W_RANGE});
    bchk(1'b1);
    repeat (40) @(posedge clk);
    spchg(32'h0);
    repeat (80) @(posedge clk);
    p0 = pos;
    repeat (100) @(posedge clk);
    check("halted", pos, p0);
    bchk(1'b1);
    stchk({OST_RUN, 16'h0003});
    check("run status", {16'h0, d[31:16]}, {16'h0, OST_RUN});
    wr(A_ACCT, 32'h0);
    spchg(32'h08000000);
    codes({E_ACC, 16'h0});
    wait_idle(40);
    stchk({OST_ERR, 16'h0002});
    wr(A_ACCT, 32'h2);
    go(32'h31, 1'b1);
    repeat (40) @(posedge clk);
    wr(A_DECT, 32'h10000);
    spchg(32'h08000000);
    codes({E_DEC, 16'h0});
    wait_idle(400);
    wr(A_DECT, 32'h2);
    wr(A_BIAS, 32'h04000000);
    go(32'h31, 1'b1);
    repeat (40) @(posedge clk);
    spchg(32'h01000000);
    codes({16'h0, W_RANGE});
    repeat (100) @(posedge clk);
    spchg(32'h0);
    codes({16'h0, W_RANGE});
    repeat (100) @(posedge clk);
    p0 = pos;
    repeat (70) @(posedge clk);
    check("bias motion", {31'h0, pos != p0}, 32'h1);
    wr(A_CTRL, 32'h8);
    wait_idle(300);
    wr(A_BIAS, 32'h0);
    $display("test speed change done");
    wr(A_NEWVAL, 32'h0);
    wr(A_CTRL, 32'h51);
    wr(A_TARGET, 32'd40);
    p0 = pos;
    go(32'h21, 1'b1);
    wait_idle(3000);
    #1 check("drive moved", pos - p0, 32'd40);
    rchk("feed", A_FEEDLO, 32'd40);
    wr(A_TARGET, 32'd400);
    wr(A_NEWSPD, 32'h04000000);
    go(32'h21, 1'b1);
    repeat (60) @(posedge clk);
    wr(A_CTRL, 32'h26);
    repeat (20) @(posedge clk);
    codes({16'h0, W_NOCHG});
    bchk(1'b1);
    wr(A_CTRL, 32'h8);
    wait_idle(300);
    $display("test position control done");
    wr(A_NEWVAL, 32'd500);
    wr(A_CTRL, 32'h51);
    wr(A_STRUP, 32'd300);
    go(32'h61, 1'b0);
    codes({E_UP, 16'h0});
    go(32'h161, 1'b1);
    codes(32'h0);
    wr(A_CTRL, 32'h8);
    wait_idle(300);
    wr(A_STRUP, 32'd1000);
    wr(A_NEWVAL, 32'h0);
    wr(A_CTRL, 32'h51);
    wr(A_TARGET, 32'd10);
    ext_switch <= 1'b1;
    go(32'h41, 1'b1);
    stchk({OST_RUN, 16'h0013});
    check("position phase", {31'h0, d[4]}, 32'h1);
    wait_idle(1000);
    ext_switch <= 1'b0;
    rchk("feed", A_FEEDLO, 32'd10);
    $display("test jog and switching done");
    summarize();
  end
endmodule : scsl_axis_bench
`default_nettype wire
